// ===== src/bcs_clk_div.sv
// divider: one-cycle enable pulses for the medium-speed bus master clocks
module bcs_clk_div
  import bcs_pkg::*;
(
  input  wire logic       clk_i,     // system clock
  input  wire logic       nrst_i,    // async reset, low
  input  wire logic [2:0] sel_i,     // bus clock select code
  output logic            bus_en_o   // bus master clock enable
);
  logic [DIV_BITS-1:0] cnt_ff;
  logic [DIV_BITS-1:0] nxt_cnt;
  logic                en;

  // free-running counter; its low bits all ones mark the end of a divided period
  assign nxt_cnt = cnt_ff + 5'h01;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // 11x reserved codes fall back to the full clock so the bus never hangs
  always_comb begin
    en = 1'b1;
    unique case (sel_i)
      3'h1: en = &cnt_ff[0:0];   // see RULE_12
      3'h2: en = &cnt_ff[1:0];
      3'h3: en = &cnt_ff[2:0];
      3'h4: en = &cnt_ff[3:0];
      3'h5: en = &cnt_ff[4:0];   // see RULE_01
      default: en = 1'b1;
    endcase
  end

  assign bus_en_o = en;
endmodule

// ===== src/bcs_pkg.sv
// package: register layout, codes and timing counts of the bus clock and standby control
package bcs_pkg;
  localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_LOW_POWER_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_STATUS          = 4'h2;

  localparam int          POS_STANDBY_SELECT   = 7;
  localparam int          POS_WAIT_SEL         = 4;
  localparam int          POS_RESERVED3        = 3;
  localparam int          POS_BUS_CLK_SEL      = 0;
  localparam int          POS_SUBCLK_ENABLE    = 0;
  localparam logic [7:0]  STANDBY_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  STANDBY_CONTROL_WMSK = 8'hF7;
  localparam logic [7:0]  LOW_POWER_CTRL_RST   = 8'h00;

  localparam logic [2:0]  CLK_SEL_FULL         = 3'h0;
  localparam int          DIV_BITS             = 5;

  localparam logic [2:0]  WAIT_CODE_RSVD       = 3'h6;
  localparam logic [2:0]  WAIT_CODE_SHORT      = 3'h7;
  localparam logic [18:0] WAIT_STATES_SHORT    = 19'h00010;
  localparam logic [18:0] WAIT_STATES_BASE     = 19'h02000;
  localparam int          WAIT_CNT_BITS        = 19;

  typedef enum logic [2:0] {
    BCS_MODE_ACTIVE, BCS_MODE_SLEEP, BCS_MODE_SW_STANDBY, BCS_MODE_SUBACTIVE,
    BCS_MODE_WATCH, BCS_MODE_SUBSLEEP
  } bcs_mode_e;

  typedef struct packed {
    logic       standby_select;
    logic [2:0] wait_time_sel;
    logic       reserved3;
    logic [2:0] bus_clk_sel;
  } bcs_standby_control_s;

  typedef struct packed {
    logic       sleep_req;
    logic       want_sub;
    logic       want_watch;
    logic       want_high;
  } bcs_sleep_req_s;
endpackage

// ===== src/bcs_top.sv
// top: bus clock select, subclock gate, sleep mode decision and stabilization wait
// Function
// RULE_01: the bus master gets the full clock or it divided by 2, 4, 8, 16 or 32 by the select field.
// RULE_02: the outside source drives a 32.768 kHz clock on the subclock pin when it is used.
// RULE_03: software makes the shared pin an input and sets the subclock enable before using it.
// RULE_04: software keeps the subclock enable cleared while no subclock is used.
// RULE_05: sleep in high or medium speed goes to sleep mode on select 0, else standby, subactive or watch.
// RULE_06: sleep in subactive goes to subsleep on select 0, else to watch or high speed.
// RULE_07: the standby select bit changes only by software writes, never by mode transitions.
// RULE_08: the wait field sets the oscillator stabilization wait on leaving standby, watch or subactive.
// RULE_09: with an external clock software should pick the shortest wait.
// RULE_10: bit 3 of the standby control register reads 0 and ignores writes.
// RULE_11: software clears the bus clock select field before going to subactive or watch.
// RULE_12: select 000 is full clock, 001 to 101 divide by 2 to 32, 11x is reserved.
// RULE_13: wait codes 000 to 101 give 8192 to 262144 states, 110 reserved, 111 gives 16 states.
// RULE_14: the bus master clock stays stopped until the stabilization counter completes.
module bcs_top
  import bcs_pkg::*;
(
  input  wire logic            clk_i,          // system clock 100 MHz
  input  wire logic            nrst_i,         // async reset, low
  input  wire logic [3:0]      addr_i,         // register address
  input  wire logic [7:0]      wdata_i,        // write data
  input  wire logic            wr_i,           // write strobe
  input  wire logic            rd_i,           // read strobe
  output logic      [7:0]      rdata_o,        // read data, next cycle
  input  wire bcs_pkg::bcs_sleep_req_s sleep_i, // sleep instruction and target hints
  input  wire logic            wake_i,         // wake interrupt pulse
  input  wire logic            subclock_input_pin_i, // raw subclock pin
  output logic                 subclk_o,       // gated, synchronised subclock level
  output logic                 bus_clk_en_o,   // bus master clock enable
  output bcs_pkg::bcs_mode_e   mode_o,         // current power mode
  output logic                 osc_wait_o      // stabilization wait running
);
  bcs_standby_control_s ctl_ff;
  logic                 subclock_input_enable_ff;
  logic [7:0]           rdata_ff;
  bcs_mode_e            mode_ff;
  bcs_mode_e            nxt_mode;
  logic [WAIT_CNT_BITS-1:0] wait_cnt_ff;
  logic                 wait_ff;
  logic                 sub_meta_ff;
  logic                 sub_sync_ff;
  logic                 div_en;

  // wait length in states for a code; 110 is treated as the longest setting
  function automatic logic [WAIT_CNT_BITS-1:0] wait_states(input logic [2:0] code);
    logic [WAIT_CNT_BITS-1:0] n;
    n = WAIT_STATES_BASE;
    if (code == WAIT_CODE_SHORT) begin
      n = WAIT_STATES_SHORT;
    end else if (code == WAIT_CODE_RSVD) begin
      n = WAIT_STATES_BASE << 5;
    end else begin
      n = WAIT_STATES_BASE << code;
    end
    return n;
  endfunction

  function automatic logic [7:0] rd_value(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_STANDBY_CONTROL: v = ctl_ff & STANDBY_CONTROL_WMSK; // see RULE_10
      ADDR_LOW_POWER_CTRL:  v = {7'h00, subclock_input_enable_ff};
      ADDR_STATUS:          v = {3'h0, wait_ff, 1'b0, mode_ff};
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  // software writes only; mode changes never touch the select bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_ff <= STANDBY_CONTROL_RST;
    end else if (wr_i && addr_i == ADDR_STANDBY_CONTROL) begin
      ctl_ff <= wdata_i & STANDBY_CONTROL_WMSK; // see RULE_07, see RULE_10
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      subclock_input_enable_ff <= LOW_POWER_CTRL_RST[POS_SUBCLK_ENABLE];
    end else if (wr_i && addr_i == ADDR_LOW_POWER_CTRL) begin
      subclock_input_enable_ff <= wdata_i[POS_SUBCLK_ENABLE];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= rd_value(addr_i);
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // subclock pin is asynchronous: two stages, then gated by the enable
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
    end else begin
      sub_meta_ff <= subclock_input_pin_i;
      sub_sync_ff <= sub_meta_ff;
    end
  end

  // sleep mode decision and wake-up
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      BCS_MODE_ACTIVE: begin
        if (sleep_i.sleep_req) begin
          if (!ctl_ff.standby_select) begin
            nxt_mode = BCS_MODE_SLEEP; // see RULE_05
          end else if (sleep_i.want_sub) begin
            nxt_mode = BCS_MODE_SUBACTIVE;
          end else if (sleep_i.want_watch) begin
            nxt_mode = BCS_MODE_WATCH;
          end else begin
            nxt_mode = BCS_MODE_SW_STANDBY; // see RULE_05
          end
        end
      end
      BCS_MODE_SUBACTIVE: begin
        if (sleep_i.sleep_req) begin
          if (!ctl_ff.standby_select) begin
            nxt_mode = BCS_MODE_SUBSLEEP; // see RULE_06
          end else if (sleep_i.want_high) begin
            nxt_mode = BCS_MODE_ACTIVE;
          end else begin
            nxt_mode = BCS_MODE_WATCH; // see RULE_06
          end
        end
      end
      BCS_MODE_SLEEP, BCS_MODE_SW_STANDBY, BCS_MODE_WATCH: begin
        if (wake_i) begin
          nxt_mode = BCS_MODE_ACTIVE;
        end
      end
      BCS_MODE_SUBSLEEP: begin
        if (wake_i) begin
          nxt_mode = BCS_MODE_SUBACTIVE;
        end
      end
      default: nxt_mode = BCS_MODE_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_ff <= BCS_MODE_ACTIVE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // oscillator restart on leaving standby, watch or subactive into high speed
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_ff     <= 1'b0;
      wait_cnt_ff <= 19'h00000;
    end else if (nxt_mode == BCS_MODE_ACTIVE && (mode_ff == BCS_MODE_SW_STANDBY ||
                 mode_ff == BCS_MODE_WATCH || mode_ff == BCS_MODE_SUBACTIVE)) begin
      wait_ff     <= 1'b1; // see RULE_08
      wait_cnt_ff <= wait_states(ctl_ff.wait_time_sel) - 19'h00001; // see RULE_13
    end else if (wait_ff) begin
      if (wait_cnt_ff == 19'h00000) begin
        wait_ff <= 1'b0; // see RULE_14
      end else begin
        wait_cnt_ff <= wait_cnt_ff - 19'h00001;
      end
    end
  end

  bcs_clk_div u_div (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .sel_i    (ctl_ff.bus_clk_sel),
    .bus_en_o (div_en)
  );

  // bus master runs only in active or subactive mode and never during the wait
  assign bus_clk_en_o = div_en && !wait_ff &&
                        (mode_ff == BCS_MODE_ACTIVE || mode_ff == BCS_MODE_SUBACTIVE); // see RULE_14, see RULE_01
  assign subclk_o   = sub_sync_ff & subclock_input_enable_ff;
  assign rdata_o    = rdata_ff;
  assign mode_o     = mode_ff;
  assign osc_wait_o = wait_ff;
endmodule

// ===== verif/bcs_top_chk.sv
// checker: port properties of the bus clock and standby control
module bcs_top_chk
  import bcs_pkg::*;
(
  input  wire logic                    clk_i,        // clock
  input  wire logic                    nrst_i,       // reset, low
  input  wire logic [3:0]              addr_i,       // address
  input  wire logic [7:0]              wdata_i,      // write data
  input  wire logic                    wr_i,         // write
  input  wire logic                    rd_i,         // read
  input  wire logic [7:0]              rdata_o,      // read data
  input  wire bcs_pkg::bcs_sleep_req_s sleep_i,      // sleep
  input  wire logic                    wake_i,       // wake
  input  wire logic                    bus_clk_en_o, // bus enable
  input  wire bcs_pkg::bcs_mode_e      mode_o,       // mode
  input  wire logic                    osc_wait_o,   // wait
  input  wire logic                    subclk_o      // gated subclock
);
  logic        exen_ff; // shadow of the subclock enable
  // enable shadow follows writes to the low power control register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exen_ff <= 1'b0;
    end else if (wr_i && addr_i == ADDR_LOW_POWER_CTRL) begin
      exen_ff <= wdata_i[POS_SUBCLK_ENABLE];
    end
  end
  logic [7:0]  ctl_ff;  // shadow of the control register
  logic [18:0] wcnt_ff; // wait cycles so far
  logic [18:0] wexp;    // wait length of the code
  // shadow follows software writes only, never mode changes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_ff <= 8'h00;
    end else if (wr_i && addr_i == ADDR_STANDBY_CONTROL) begin
      ctl_ff <= wdata_i & STANDBY_CONTROL_WMSK;
    end
  end
  // count the wait; a rewrite of the code mid-wait is not modelled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wcnt_ff <= 19'h00000;
    end else begin
      wcnt_ff <= osc_wait_o ? wcnt_ff + 19'h00001 : 19'h00000;
    end
  end
  assign wexp = (ctl_ff[6:4] == 3'h7) ? 19'h00010 :
                (ctl_ff[6:4] == 3'h6) ? 19'h40000 : 19'h02000 << ctl_ff[6:4];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_WAIT_STOP: assert property (osc_wait_o |-> !bus_clk_en_o)
    else $error("bus clock ran in wait");
  AST_WAIT_LEN: assert property ($fell(osc_wait_o) |-> wcnt_ff == wexp)
    else $error("wait length wrong");
  AST_WAIT_ACT: assert property ($rose(osc_wait_o) |-> mode_o == BCS_MODE_ACTIVE &&
    $past(mode_o) inside {BCS_MODE_SW_STANDBY, BCS_MODE_WATCH, BCS_MODE_SUBACTIVE})
    else $error("wait from wrong mode");
  AST_RD_B3: assert property (rd_i && addr_i == ADDR_STANDBY_CONTROL |=>
    rdata_o == {ctl_ff[7:4], 1'b0, ctl_ff[2:0]}) else $error("control read wrong");
  AST_SLP0: assert property (sleep_i.sleep_req && mode_o == BCS_MODE_ACTIVE && !ctl_ff[7]
    |=> mode_o == BCS_MODE_SLEEP) else $error("no sleep mode");
  AST_SLP1: assert property (sleep_i.sleep_req && mode_o == BCS_MODE_ACTIVE && ctl_ff[7]
    |=> mode_o inside {BCS_MODE_SW_STANDBY, BCS_MODE_SUBACTIVE, BCS_MODE_WATCH})
    else $error("no standby mode");
  AST_SUB: assert property (sleep_i.sleep_req && mode_o == BCS_MODE_SUBACTIVE |=>
    mode_o == (!$past(ctl_ff[7]) ? BCS_MODE_SUBSLEEP : $past(sleep_i.want_high) ?
    BCS_MODE_ACTIVE : BCS_MODE_WATCH)) else $error("subactive sleep wrong");
  AST_FULL: assert property (ctl_ff[2:0] == CLK_SEL_FULL && mode_o == BCS_MODE_ACTIVE &&
    !osc_wait_o |-> bus_clk_en_o) else $error("full clock missing");
  AST_DIV2: assert property (ctl_ff[2:0] == 3'h1 && bus_clk_en_o && !wr_i |=>
    !bus_clk_en_o) else $error("half clock wrong");
  AST_SUB_GATE: assert property (!exen_ff |-> !subclk_o)
    else $error("subclock passed while disabled");
  cover property ($fell(osc_wait_o));
  cover property (mode_o == BCS_MODE_SUBSLEEP);
  cover property (mode_o == BCS_MODE_WATCH);
endmodule

// ===== verif/test_bcs_top.sv
// bench: self-checking test of the bus clock and standby control
module test_bcs_top import bcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk_i = 1'b0;
  logic           nrst_i = 1'b0;
  logic           wr_i = 1'b0;
  logic           rd_i = 1'b0;
  logic           wake_i = 1'b0;
  logic [3:0]     addr_i = 4'h0;
  logic [7:0]     wdata_i = 8'h00;
  logic [7:0]     rdata_o;
  bcs_sleep_req_s sleep_i = 4'h0;
  logic           bus_clk_en_o;
  logic           subclock_input_pin_i = 1'b0;
  logic           subclk_o;
  logic           osc_wait_o;
  bcs_mode_e      mode_o;
  int             fails = 0;
  int             comparisons = 0;
  int             n;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  always #5 clk_i = ~clk_i;
  // subclock pin driven by the bench as a slow outside clock
  bcs_top bcs_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .wake_i(wake_i),
    .subclock_input_pin_i(subclock_input_pin_i), .subclk_o(subclk_o),
    .bus_clk_en_o(bus_clk_en_o),
    .mode_o(mode_o), .osc_wait_o(osc_wait_o));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic slp(input bcs_sleep_req_s s);
    @(posedge clk_i);
    sleep_i <= s;
    @(posedge clk_i);
    sleep_i <= 4'h0;
    @(negedge clk_i);
  endtask
  task automatic wake();
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // bounded count of the stabilization wait
  task automatic wait_len(input int e);
    n = 0;
    `CHK(mode_o, BCS_MODE_ACTIVE)
    while (osc_wait_o === 1'b1 && n < e + 8) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n, e)
    if (n >= e + 8) complete_run();
  endtask
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_STANDBY_CONTROL, d);
    `CHK(d, 8'h00)
    wr(ADDR_STANDBY_CONTROL, 8'hFF);
    rd(ADDR_STANDBY_CONTROL, d);
    `CHK(d, 8'hF7)
    rd(4'hF, d);
    `CHK(d, 8'h00)
  endtask
  // pin toggled slowly as the outside subclock; the gate follows the enable bit
  task automatic t_subclk();
    logic [7:0] d;
    wr(ADDR_LOW_POWER_CTRL, 8'h01);
    rd(ADDR_LOW_POWER_CTRL, d);
    `CHK(d, 8'h01)
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      subclock_input_pin_i <= ~k[0];
      repeat (3) @(posedge clk_i);
      if (k == 2) wr(ADDR_LOW_POWER_CTRL, 8'h00);
      @(negedge clk_i);
      `CHK(subclk_o, (k == 0))
    end
    @(posedge clk_i);
    subclock_input_pin_i <= 1'b0;
    rd(ADDR_LOW_POWER_CTRL, d);
    `CHK(d, 8'h00)
  endtask
  // pulses in 64 cycles for select codes 000 to 110
  task automatic t_div();
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_STANDBY_CONTROL, 8'(k));
      n = 0;
      repeat (64) begin
        @(negedge clk_i);
        n += bus_clk_en_o;
      end
      `CHK(n, (k == 6) ? 64 : 64 >> k)
    end
  endtask
  task automatic t_sleep();
    logic [7:0] d;
    wr(ADDR_STANDBY_CONTROL, 8'h00);
    slp(4'h8);
    `CHK(mode_o, BCS_MODE_SLEEP)
    wake();
    `CHK(osc_wait_o, 1'b0)
    wr(ADDR_STANDBY_CONTROL, 8'hF0);
    slp(4'h8);
    `CHK(mode_o, BCS_MODE_SW_STANDBY)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h02)
    wake();
    wait_len(16);
    rd(ADDR_STANDBY_CONTROL, d);
    `CHK(d, 8'hF0)
  endtask
  task automatic t_sub();
    wr(ADDR_STANDBY_CONTROL, 8'h80);
    slp(4'hC);
    `CHK(mode_o, BCS_MODE_SUBACTIVE)
    slp(4'hA);
    `CHK(mode_o, BCS_MODE_WATCH)
    wake();
    wait_len(8192);
    slp(4'hC);
    wr(ADDR_STANDBY_CONTROL, 8'h00);
    slp(4'h8);
    `CHK(mode_o, BCS_MODE_SUBSLEEP)
    wake();
    `CHK(mode_o, BCS_MODE_SUBACTIVE)
    wr(ADDR_STANDBY_CONTROL, 8'hA0);
    slp(4'h9);
    wait_len(32768);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_subclk();
    t_div();
    t_sleep();
    t_sub();
    complete_run();
  end
endmodule
bind bcs_top bcs_top_chk bcs_top_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
  .wake_i(wake_i), .bus_clk_en_o(bus_clk_en_o), .mode_o(mode_o), .osc_wait_o(osc_wait_o),
  .subclk_o(subclk_o));
